/* File: verilog/tle_pkg.sv */
// Operation
// - Alert pin stays disabled after power-up.
// - Limit words: two's complement, quarter-degree steps.
// - Top three temperature bits report raw trip status.
// - Low thirteen bits hold temperature, sign bit twelve, LSB one sixteenth degree.
// - Reserved upper bits ignore writes and read zero.
// - Capability bit seven: shutdown clears alert state when one, freezes when zero.
// - Stalled bus released after 25 to 35 ms.
// - Resolution field codes 00 to 11 map half to sixteenth degree steps.
// - Shutdown lets clear writes clear alert state, never set it.
// - Hysteresis field selects none, 1.5, 3 or 6 degrees.
// - Halt stops conversions; set refused under lock, clear always allowed.
// - Critical freeze blocks critical limit writes; only reset clears it.
// - Alarm lock bit blocks high and low limit writes; only reset clears it.
// - Clear bit clears latched alert in interrupt behaviour or while halted; reads zero.
// - Clear cannot deassert alert above critical limit.
// - Config bit four copies asserted alert state.
// - Disabled pin released if active low, grounded if high.
// - Critical-only bit limits alert to critical crossings.
// - Polarity bit selects active low or high; pin always open drain.
// - Behaviour bit selects comparator or latched interrupt behaviour.
// - Either lock freezes hysteresis, enable, polarity and behaviour bits.
// - Critical-only bit cannot be set while alarm lock is set.
// - Trip bits: at/above critical, above high, below low; else zero.
// - Interrupt behaviour asserts on each crossing until cleared.
// - Comparator behaviour asserts whenever temperature is outside the window.
// - Two lowest bits of every limit word are always zero.
package tle_pkg;

    // ========================================================
    // Register pointers
    localparam logic [2:0] PTR_CAP   = 3'h0;
    localparam logic [2:0] PTR_CFG   = 3'h1;
    localparam logic [2:0] PTR_HIGH  = 3'h2;
    localparam logic [2:0] PTR_LOW   = 3'h3;
    localparam logic [2:0] PTR_CRIT  = 3'h4;
    localparam logic [2:0] PTR_TEMP  = 3'h5;
    localparam logic [2:0] PTR_MAKER = 3'h6;
    localparam logic [2:0] PTR_PART  = 3'h7;

    // ========================================================
    // Reset and fixed values
    localparam logic [15:0] CAP_VALUE  = 16'h007f; // bit6 timeout, bits4:3 = 11
    localparam logic [15:0] CFG_RESET  = 16'h0000;
    localparam logic [15:0] LIM_RESET  = 16'h0000;
    localparam logic [15:0] LIM_MASK   = 16'h1ffc; // top three and low two bits zero
    localparam logic [15:0] CFG_MASK   = 16'h07ff;
    localparam int          CAP_SHUTDOWN_ALERT_BEHAVIOUR_BIT = 7;

    // ========================================================
    // Configuration bit positions
    localparam int CFG_MODE   = 0;
    localparam int CFG_POL    = 1;
    localparam int CFG_CONLY  = 2;
    localparam int CFG_OEN    = 3;
    localparam int CFG_STS    = 4;
    localparam int CFG_CLEAR  = 5;
    localparam int CFG_ALOCK  = 6;
    localparam int CFG_CLOCK  = 7;
    localparam int CFG_HALT   = 8;
    localparam int CFG_HYS_LO = 9;
    localparam int CFG_HYS_HI = 10;

    // ========================================================
    // Hysteresis offsets in sixteenth-degree steps
    localparam logic [13:0] HYS_0   = 14'h0000;
    localparam logic [13:0] HYS_1P5 = 14'h0018; // 1.5 degrees
    localparam logic [13:0] HYS_3   = 14'h0030; // 3 degrees
    localparam logic [13:0] HYS_6   = 14'h0060; // 6 degrees

    // ========================================================
    // Bus timeout
    localparam int CLK_MHZ        = 50;
    localparam int TMO_MIN_MS     = 25;
    localparam int TMO_MAX_MS     = 35;
    localparam int TMO_CYCLES     = TMO_MIN_MS * 1000 * CLK_MHZ; // least time
    localparam int TMO_MAX_CYCLES = TMO_MAX_MS * 1000 * CLK_MHZ;

endpackage

/* File: verilog/tle_sensor_regs.sv */
`timescale 1ns/1ps
module tle_sensor_regs #(
    parameter int          TIMEOUT_CYCLES = tle_pkg::TMO_CYCLES, // bus stall release
    parameter logic [15:0] MAKER_ID       = 16'h00a5,            // arbitrary value
    parameter logic [15:0] PART_REV_ID    = 16'h0101             // arbitrary value
) (
    input  wire logic        i_clk,          // core clock, 50 MHz
    input  wire logic        i_rst_n,        // synchronous reset, power-on
    // Link side, on the serial bus controller clock
    input  wire logic        i_lnk_clk,      // link clock
    input  wire logic        i_lnk_rst_n,    // link synchronous reset
    input  wire logic        i_lnk_wr,       // register write pulse
    input  wire logic        i_lnk_rd,       // register read pulse
    input  wire logic [2:0]  i_lnk_ptr,      // register pointer
    input  wire logic [15:0] i_lnk_wdata,    // write data
    input  wire logic        i_lnk_stall,    // transaction in progress, level
    output logic             o_lnk_busy,     // request in flight
    output logic             o_lnk_done,     // request finished, one pulse
    output logic [15:0]      o_lnk_rdata,    // read data
    output logic             o_lnk_timeout,  // stalled transaction release
    // Converter side, core clock
    input  wire logic        i_conv_valid,   // new sample pulse
    input  wire logic [12:0] i_conv_temp,    // sample, two's complement
    output logic             o_conv_enable,  // converter runs
    // Open-drain alert pin
    input  wire logic        i_alert_i,      // pin level, unused by logic
    output logic             o_alert_o,      // pin output value, always low
    output logic             o_alert_oe_n    // low while pulling the pin low
);

    // ========================================================
    // Link side: capture request and send it over as a toggle
    logic        lreq_tgl_reg;
    logic        lbusy_reg;
    logic        lwr_reg;
    logic [2:0]  lptr_reg;
    logic [15:0] lwdata_reg;
    logic        lack_s1_reg;
    logic        lack_s2_reg;
    logic        lack_s3_reg;
    logic        ldone_reg;
    logic [15:0] lrdata_reg;
    logic        ltmo_s1_reg;
    logic        ltmo_s2_reg;
    logic        tmo_reg;
    logic        ack_tgl_reg;
    logic [15:0] rdata_reg;

    wire lnk_take = (i_lnk_wr | i_lnk_rd) & ~lbusy_reg; // requests while busy ignored
    wire lnk_ack  = lack_s2_reg ^ lack_s3_reg;

    // Request capture; fields held stable until the answer returns
    always_ff @(posedge i_lnk_clk) begin
        if (!i_lnk_rst_n) begin
            lreq_tgl_reg <= 1'b0;
            lbusy_reg    <= 1'b0;
            lwr_reg      <= 1'b0;
            lptr_reg     <= 3'h0;
            lwdata_reg   <= 16'h0000;
        end else if (lnk_take) begin
            lreq_tgl_reg <= ~lreq_tgl_reg;
            lbusy_reg    <= 1'b1;
            lwr_reg      <= i_lnk_wr;
            lptr_reg     <= i_lnk_ptr;
            lwdata_reg   <= i_lnk_wdata;
        end else if (lnk_ack) begin
            lbusy_reg    <= 1'b0;
        end
    end

    // Answer return; read data held stable by the core while toggle travels
    always_ff @(posedge i_lnk_clk) begin
        if (!i_lnk_rst_n) begin
            lack_s1_reg <= 1'b0;
            lack_s2_reg <= 1'b0;
            lack_s3_reg <= 1'b0;
            ldone_reg   <= 1'b0;
            lrdata_reg  <= 16'h0000;
            ltmo_s1_reg <= 1'b0;
            ltmo_s2_reg <= 1'b0;
        end else begin
            lack_s1_reg <= ack_tgl_reg;
            lack_s2_reg <= lack_s1_reg;
            lack_s3_reg <= lack_s2_reg;
            ldone_reg   <= lnk_ack;
            if (lnk_ack)
                lrdata_reg <= rdata_reg;
            ltmo_s1_reg <= tmo_reg;
            ltmo_s2_reg <= ltmo_s1_reg;
        end
    end

    assign o_lnk_busy    = lbusy_reg;
    assign o_lnk_done    = ldone_reg;
    assign o_lnk_rdata   = lrdata_reg;
    assign o_lnk_timeout = ltmo_s2_reg;

    // ========================================================
    // Core side: receive the request toggle
    logic req_s1_reg;
    logic req_s2_reg;
    logic req_s3_reg;
    logic stall_s1_reg;
    logic stall_s2_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            req_s1_reg   <= 1'b0;
            req_s2_reg   <= 1'b0;
            req_s3_reg   <= 1'b0;
            stall_s1_reg <= 1'b0;
            stall_s2_reg <= 1'b0;
        end else begin
            req_s1_reg   <= lreq_tgl_reg;
            req_s2_reg   <= req_s1_reg;
            req_s3_reg   <= req_s2_reg;
            stall_s1_reg <= i_lnk_stall;
            stall_s2_reg <= stall_s1_reg;
        end
    end

    // Request fields are stable while the toggle is in flight
    wire req_hit = req_s2_reg ^ req_s3_reg;
    wire wr_hit  = req_hit & lwr_reg;
    wire wr_cfg  = wr_hit & (lptr_reg == tle_pkg::PTR_CFG);
    wire wr_high = wr_hit & (lptr_reg == tle_pkg::PTR_HIGH);
    wire wr_low  = wr_hit & (lptr_reg == tle_pkg::PTR_LOW);
    wire wr_crit = wr_hit & (lptr_reg == tle_pkg::PTR_CRIT);

    // ========================================================
    // Configuration and limit registers
    logic [15:0] cfg_reg;
    logic [15:0] high_reg;
    logic [15:0] low_reg;
    logic [15:0] crit_reg;
    logic [15:0] cfg_next;

    wire        locked   = cfg_reg[tle_pkg::CFG_ALOCK] | cfg_reg[tle_pkg::CFG_CLOCK];
    wire [15:0] wd       = lwdata_reg;
    wire        halt_req = wd[tle_pkg::CFG_HALT];
    wire        conly_wr = wd[tle_pkg::CFG_CONLY] & ~cfg_reg[tle_pkg::CFG_ALOCK];

    // Next configuration on a write; status and clear bits never stored
    always_comb begin
        cfg_next = cfg_reg;
        if (!locked) begin
            cfg_next[tle_pkg::CFG_HYS_HI:tle_pkg::CFG_HYS_LO] =
                wd[tle_pkg::CFG_HYS_HI:tle_pkg::CFG_HYS_LO];
            cfg_next[tle_pkg::CFG_OEN]  = wd[tle_pkg::CFG_OEN];
            cfg_next[tle_pkg::CFG_POL]  = wd[tle_pkg::CFG_POL];
            cfg_next[tle_pkg::CFG_MODE] = wd[tle_pkg::CFG_MODE];
        end
        cfg_next[tle_pkg::CFG_HALT]  = halt_req & (~locked | cfg_reg[tle_pkg::CFG_HALT]);
        cfg_next[tle_pkg::CFG_CLOCK] = cfg_reg[tle_pkg::CFG_CLOCK] | wd[tle_pkg::CFG_CLOCK];
        cfg_next[tle_pkg::CFG_ALOCK] = cfg_reg[tle_pkg::CFG_ALOCK] | wd[tle_pkg::CFG_ALOCK];
        cfg_next[tle_pkg::CFG_CONLY] = conly_wr;
        cfg_next[tle_pkg::CFG_STS]   = 1'b0;
        cfg_next[tle_pkg::CFG_CLEAR] = 1'b0;
        cfg_next = cfg_next & tle_pkg::CFG_MASK;
    end

    // Reset value leaves the output disabled and released
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            cfg_reg <= tle_pkg::CFG_RESET;
        else if (wr_cfg)
            cfg_reg <= cfg_next;
    end

    // Limit words, masked so unused bits stay zero
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            high_reg <= tle_pkg::LIM_RESET;
            low_reg  <= tle_pkg::LIM_RESET;
            crit_reg <= tle_pkg::LIM_RESET;
        end else begin
            if (wr_high && !cfg_reg[tle_pkg::CFG_ALOCK])
                high_reg <= wd & tle_pkg::LIM_MASK;
            if (wr_low && !cfg_reg[tle_pkg::CFG_ALOCK])
                low_reg  <= wd & tle_pkg::LIM_MASK;
            if (wr_crit && !cfg_reg[tle_pkg::CFG_CLOCK])
                crit_reg <= wd & tle_pkg::LIM_MASK;
        end
    end

    // ========================================================
    // Temperature sample, frozen while halted
    logic [12:0] temp_reg;
    wire         halted = cfg_reg[tle_pkg::CFG_HALT];

    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            temp_reg <= 13'h0000;
        else if (i_conv_valid && !halted)
            temp_reg <= i_conv_temp;
    end

    assign o_conv_enable = ~halted;

    // ========================================================
    // Comparisons in signed sixteenth-degree units, one bit of headroom
    logic [13:0] hys;
    always_comb begin
        case (cfg_reg[tle_pkg::CFG_HYS_HI:tle_pkg::CFG_HYS_LO])
            2'b01:   hys = tle_pkg::HYS_1P5;
            2'b10:   hys = tle_pkg::HYS_3;
            2'b11:   hys = tle_pkg::HYS_6;
            default: hys = tle_pkg::HYS_0;
        endcase
    end

    wire signed [13:0] t_s   = {temp_reg[12], temp_reg};
    wire signed [13:0] hi_s  = {high_reg[12], high_reg[12:0]};
    wire signed [13:0] lo_s  = {low_reg[12], low_reg[12:0]};
    wire signed [13:0] cr_s  = {crit_reg[12], crit_reg[12:0]};
    wire signed [13:0] hi_rl = hi_s - $signed(hys);
    wire signed [13:0] cr_rl = cr_s - $signed(hys);
    wire signed [13:0] lo_rl = lo_s + $signed(hys);

    // Raw trip status, no hysteresis and no alert settings involved
    wire trip_crit = (t_s >= cr_s);
    wire trip_high = (t_s >  hi_s);
    wire trip_low  = (t_s <  lo_s);

    // Event conditions with hysteresis on release
    logic cnd_crit_reg;
    logic cnd_high_reg;
    logic cnd_low_reg;

    // Held while halted so the alert reflects the state before shutdown
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnd_crit_reg <= 1'b0;
            cnd_high_reg <= 1'b0;
            cnd_low_reg  <= 1'b0;
        end else if (!halted) begin
            cnd_crit_reg <= trip_crit | (cnd_crit_reg & (t_s >= cr_rl));
            cnd_high_reg <= trip_high | (cnd_high_reg & (t_s >  hi_rl));
            cnd_low_reg  <= trip_low  | (cnd_low_reg  & (t_s <  lo_rl));
        end
    end

    // ========================================================
    // Alert state
    wire conly    = cfg_reg[tle_pkg::CFG_CONLY];
    wire win_cond = cnd_crit_reg | (~conly & (cnd_high_reg | cnd_low_reg));
    wire [2:0] trig_vec = {cnd_crit_reg, cnd_high_reg & ~conly, cnd_low_reg & ~conly};
    logic [2:0] trig_prev_reg;
    logic       evt_reg;
    logic       clr_pend_reg;

    // A limit write or a new sample both act as soon as stored
    wire crossing  = ~halted & (trig_vec != trig_prev_reg);
    wire irq_mode  = cfg_reg[tle_pkg::CFG_MODE];
    wire clr_wr    = wr_cfg & wd[tle_pkg::CFG_CLEAR];
    wire clr_req   = clr_wr | clr_pend_reg;
    wire clr_now   = clr_req & (irq_mode | halted) & ~cnd_crit_reg;
    wire halt_rise = wr_cfg & cfg_next[tle_pkg::CFG_HALT] & ~halted;
    wire shutdown_alert_behaviour      = tle_pkg::CAP_VALUE[tle_pkg::CAP_SHUTDOWN_ALERT_BEHAVIOUR_BIT];

    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            trig_prev_reg <= 3'h0;
        else if (!halted)
            trig_prev_reg <= trig_vec;
    end

    // Set wins over clear; shutdown never sets
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            evt_reg <= 1'b0;
        end else if (halted) begin
            if (clr_now)
                evt_reg <= 1'b0;
        end else if (halt_rise && shutdown_alert_behaviour) begin
            evt_reg <= 1'b0;
        end else if (!irq_mode) begin
            evt_reg <= win_cond;
        end else if (crossing || cnd_crit_reg) begin
            evt_reg <= 1'b1;
        end else if (clr_now) begin
            evt_reg <= 1'b0;
        end
    end

    // A clear taken while above critical waits until it drops below, then loses to the crossing set in that cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            clr_pend_reg <= 1'b0;
        else if (!irq_mode || clr_now)
            clr_pend_reg <= 1'b0;
        else if (clr_wr && cnd_crit_reg)
            clr_pend_reg <= 1'b1;
    end

    // ========================================================
    // Open-drain pin drive, registered
    wire  oen       = cfg_reg[tle_pkg::CFG_OEN];
    wire  pol_high  = cfg_reg[tle_pkg::CFG_POL];
    wire  asserted  = evt_reg & oen;
    wire  pull_low  = oen ? (pol_high ? ~evt_reg : evt_reg) : pol_high;
    logic pull_low_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            pull_low_reg <= 1'b0;
        else
            pull_low_reg <= pull_low;
    end

    assign o_alert_o    = 1'b0;
    assign o_alert_oe_n = ~pull_low_reg;

    // ========================================================
    // Bus stall timeout counter
    logic [31:0] tmo_cnt_reg;

    // Counts the synchronised stall level; resets whenever it drops
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tmo_cnt_reg <= 32'h0000_0000;
            tmo_reg     <= 1'b0;
        end else if (!stall_s2_reg) begin
            tmo_cnt_reg <= 32'h0000_0000;
            tmo_reg     <= 1'b0;
        end else if (tmo_cnt_reg >= 32'(TIMEOUT_CYCLES - 1)) begin
            tmo_reg     <= 1'b1;
        end else begin
            tmo_cnt_reg <= tmo_cnt_reg + 32'h0000_0001;
        end
    end

    // ========================================================
    // Read multiplexer
    wire [15:0] cfg_rd  = {cfg_reg[15:5], asserted, cfg_reg[3:0]} & tle_pkg::CFG_MASK;
    wire [15:0] temp_rd = {trip_crit, trip_high, trip_low, temp_reg};
    logic [15:0] rd_mux;

    always_comb begin
        case (lptr_reg)
            tle_pkg::PTR_CAP:   rd_mux = tle_pkg::CAP_VALUE;
            tle_pkg::PTR_CFG:   rd_mux = cfg_rd;
            tle_pkg::PTR_HIGH:  rd_mux = high_reg;
            tle_pkg::PTR_LOW:   rd_mux = low_reg;
            tle_pkg::PTR_CRIT:  rd_mux = crit_reg;
            tle_pkg::PTR_TEMP:  rd_mux = temp_rd;
            tle_pkg::PTR_MAKER: rd_mux = MAKER_ID;
            tle_pkg::PTR_PART:  rd_mux = PART_REV_ID;
            default:            rd_mux = 16'h0000;
        endcase
    end

    // Answer word captured once, then the acknowledge toggle goes back
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_reg   <= 16'h0000;
            ack_tgl_reg <= 1'b0;
        end else if (req_hit) begin
            rdata_reg   <= lwr_reg ? 16'h0000 : rd_mux;
            ack_tgl_reg <= ~ack_tgl_reg;
        end
    end

endmodule

/* File: dv/tle_sensor_regs_monitor.sv */
`timescale 1ns/1ps
// ==============================================
// Sensor register checks
module tle_sensor_regs_monitor #(
    parameter int TIMEOUT_CYCLES = 20 // stall release count
) (
    input wire logic        i_clk,         // core clock
    input wire logic        i_rst_n,       // core reset
    input wire logic        i_lnk_clk,     // link clock
    input wire logic        i_lnk_rst_n,   // link reset
    input wire logic        i_lnk_wr,      // write pulse
    input wire logic        i_lnk_rd,      // read pulse
    input wire logic [2:0]  i_lnk_ptr,     // pointer
    input wire logic        i_lnk_stall,   // stall level
    input wire logic        o_lnk_busy,    // in flight
    input wire logic        o_lnk_done,    // answer
    input wire logic [15:0] o_lnk_rdata,   // read word
    input wire logic        o_lnk_timeout, // stall release
    input wire logic        o_conv_enable, // converter runs
    input wire logic        o_alert_o,     // pin value
    input wire logic        o_alert_oe_n   // pin enable
);
    logic       rd_reg;
    logic [2:0] ptr_reg;
    logic [5:0] stall_reg;
    wire        take    = (i_lnk_wr | i_lnk_rd) & ~o_lnk_busy;
    wire        rd_done = o_lnk_done & rd_reg;
    // Remember the request in flight; stall length saturates at 60
    always_ff @(posedge i_lnk_clk) begin
        if (!i_lnk_rst_n) begin
            rd_reg    <= 1'b0;
            ptr_reg   <= 3'h0;
            stall_reg <= 6'h00;
        end else begin
            if (take) begin
                rd_reg  <= ~i_lnk_wr;
                ptr_reg <= i_lnk_ptr;
            end
            stall_reg <= !i_lnk_stall ? 6'h00 : (stall_reg == 6'h3c ? stall_reg : stall_reg + 6'h01);
        end
    end
    sequence s_read_done(p);
        rd_done && ptr_reg == p;
    endsequence
    property p_cap_value;
        @(posedge i_lnk_clk) disable iff (!i_lnk_rst_n) s_read_done(3'h0) |-> o_lnk_rdata == 16'h007f;
    endproperty
    a_cap_value: assert property (p_cap_value) else $error("capability word wrong");
    property p_cfg_rsvd;
        @(posedge i_lnk_clk) disable iff (!i_lnk_rst_n)
            s_read_done(3'h1) |-> o_lnk_rdata[15:11] == 5'h00 && !o_lnk_rdata[5];
    endproperty
    a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config zero bits set");
    property p_halt_copy;
        @(posedge i_lnk_clk) disable iff (!i_lnk_rst_n) s_read_done(3'h1) |-> o_lnk_rdata[8] == !o_conv_enable;
    endproperty
    a_halt_copy: assert property (p_halt_copy) else $error("halt bit and converter differ");
    property p_lim_zero;
        @(posedge i_lnk_clk) disable iff (!i_lnk_rst_n) rd_done && ptr_reg inside {3'h2, 3'h3, 3'h4}
            |-> o_lnk_rdata[1:0] == 2'h0 && o_lnk_rdata[15:13] == 3'h0;
    endproperty
    a_lim_zero: assert property (p_lim_zero) else $error("limit zero bits set");
    property p_done_lat;
        @(posedge i_lnk_clk) disable iff (!i_lnk_rst_n) take |-> ##[4:14] o_lnk_done;
    endproperty
    a_done_lat: assert property (p_done_lat) else $error("request not answered");
    property p_tmo_early;
        @(posedge i_lnk_clk) disable iff (!i_lnk_rst_n)
            $rose(o_lnk_timeout) |-> int'(stall_reg) * 3 >= TIMEOUT_CYCLES * 5;
    endproperty
    a_tmo_early: assert property (p_tmo_early) else $error("timeout too early");
    property p_tmo_late;
        @(posedge i_lnk_clk) disable iff (!i_lnk_rst_n) stall_reg == 6'h3c |-> o_lnk_timeout;
    endproperty
    a_tmo_late: assert property (p_tmo_late) else $error("timeout missing");
    property p_oe_reset;
        @(posedge i_clk) disable iff (!i_rst_n) $rose(i_rst_n) |-> o_alert_oe_n [*3];
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("pin active after reset");
    property p_pin_low;
        @(posedge i_clk) disable iff (!i_rst_n) o_alert_o == 1'b0;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin driven high");
endmodule
bind tle_sensor_regs tle_sensor_regs_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
    u_tle_sensor_regs_monitor (.*);

/* File: dv/tle_host_model.sv */
`timescale 1ns/1ps
// ==============================================
// Link-side bus controller
module tle_host_model (
    input  wire logic        i_clk,   // link clock
    input  wire logic        i_done,  // answer pulse
    input  wire logic [15:0] i_rdata, // read word
    output logic             o_wr,    // write pulse
    output logic             o_rd,    // read pulse
    output logic [2:0]       o_ptr,   // pointer
    output logic [15:0]      o_wdata, // write word
    output logic             o_stall  // bus stalled
);
    initial begin
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_ptr   = 3'h0;
        o_wdata = 16'h0000;
        o_stall = 1'b0;
    end
    // Unknown word comes back if no answer arrives in 30 cycles
    task automatic xfer(input logic w, input logic [2:0] p, input logic [15:0] d,
                        output logic [15:0] q);
        int n;
        n = 0;
        q = 16'hxxxx;
        @(negedge i_clk);
        o_wr    <= w;
        o_rd    <= !w;
        o_ptr   <= p;
        o_wdata <= d;
        @(negedge i_clk);
        o_wr    <= 1'b0;
        o_rd    <= 1'b0;
        o_wdata <= ~d;
        while (i_done !== 1'b1 && n < 30) begin
            @(negedge i_clk);
            n++;
        end
        if (i_done === 1'b1) q = i_rdata;
    endtask
    task automatic stall(input logic s);
        @(negedge i_clk);
        o_stall <= s;
    endtask
endmodule

/* File: dv/tle_sensor_regs_test.sv */
`timescale 1ns/1ps
// ==============================================
// Register, alert and timeout tests
module tle_sensor_regs_test;
    localparam logic [15:0] MAKER = 16'h005a; // arbitrary value
    localparam logic [15:0] PART  = 16'h0203; // arbitrary value
    logic        clk, lclk, rst_n, valid;
    logic [12:0] temp;
    logic [15:0] q;
    logic [15:0] rv [8] = '{16'h007f, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000, MAKER, PART};
    wire         wr, rd, stall, busy, done, tmo, conv_en, alert_o, oe_n;
    wire  [2:0]  ptr;
    wire  [15:0] wdata, rdata;
    int          errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    tle_sensor_regs #(.TIMEOUT_CYCLES(20), .MAKER_ID(MAKER), .PART_REV_ID(PART)) u_tle_sensor_regs (
        .i_clk(clk), .i_rst_n(rst_n), .i_lnk_clk(lclk), .i_lnk_rst_n(rst_n), .i_lnk_wr(wr),
        .i_lnk_rd(rd), .i_lnk_ptr(ptr), .i_lnk_wdata(wdata), .i_lnk_stall(stall),
        .o_lnk_busy(busy), .o_lnk_done(done), .o_lnk_rdata(rdata), .o_lnk_timeout(tmo),
        .i_conv_valid(valid), .i_conv_temp(temp), .o_conv_enable(conv_en),
        .i_alert_i(oe_n), .o_alert_o(alert_o), .o_alert_oe_n(oe_n));
    tle_host_model u_tle_host_model (.i_clk(lclk), .i_done(done), .i_rdata(rdata), .o_wr(wr),
        .o_rd(rd), .o_ptr(ptr), .o_wdata(wdata), .o_stall(stall));
    // Clocks unrelated in phase
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #3;
        forever #6 lclk = ~lclk;
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wreg(input logic [2:0] p, input logic [15:0] d);
        u_tle_host_model.xfer(1'b1, p, d, q);
    endtask
    task automatic rreg(input logic [2:0] p, input logic [15:0] e);
        u_tle_host_model.xfer(1'b0, p, 16'h0000, q);
        chk($sformatf("reg%0d", p), q, e);
    endtask
    // Pin lags a sample by four core cycles
    task automatic conv(input logic [12:0] t);
        @(negedge clk);
        valid <= 1'b1;
        temp  <= t;
        @(negedge clk);
        valid <= 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic pin(input logic e);
        repeat (4) @(negedge clk);
        chk("alert_oe_n", {15'h0, oe_n}, {15'h0, e});
    endtask
    task automatic end_of_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard, well above the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        rst_n = 1'b0;
        valid = 1'b0;
        temp  = 13'h0000;
        repeat (3) @(negedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("alert_oe_n", {15'h0, oe_n}, 16'h0001);
        chk("conv_enable", {15'h0, conv_en}, 16'h0001);
        for (int i = 0; i < 8; i++) rreg(i[2:0], rv[i]);
        wreg(3'h0, 16'hffff);
        rreg(3'h0, 16'h007f);
        wreg(3'h1, 16'hf800);
        rreg(3'h1, 16'h0000);
        wreg(3'h2, 16'hffff);
        rreg(3'h2, 16'h1ffc);
        wreg(3'h2, 16'h0190);
        wreg(3'h3, 16'h0050);
        wreg(3'h4, 16'h0320);
        rreg(3'h3, 16'h0050);
        $display("test registers done");
        wreg(3'h1, 16'h0008);
        conv(13'h0200);
        rreg(3'h5, 16'h4200);
        pin(1'b0);
        rreg(3'h1, 16'h0018);
        conv(13'h0400);
        rreg(3'h5, 16'hc400);
        conv(13'h1e70);
        rreg(3'h5, 16'h3e70);
        wreg(3'h1, 16'h0028);
        pin(1'b0);
        conv(13'h0100);
        pin(1'b1);
        wreg(3'h1, 16'h0608);
        conv(13'h0200);
        conv(13'h0180);
        pin(1'b0);
        conv(13'h0120);
        pin(1'b1);
        wreg(3'h1, 16'h000a);
        pin(1'b0);
        wreg(3'h1, 16'h0002);
        pin(1'b0);
        wreg(3'h1, 16'h000c);
        conv(13'h0200);
        pin(1'b1);
        conv(13'h0400);
        pin(1'b0);
        conv(13'h0100);
        $display("test comparator done");
        wreg(3'h1, 16'h0009);
        conv(13'h0200);
        pin(1'b0);
        wreg(3'h1, 16'h0029);
        pin(1'b1);
        rreg(3'h1, 16'h0009);
        conv(13'h0400);
        wreg(3'h1, 16'h0029);
        pin(1'b0);
        wreg(3'h1, 16'h0109);
        chk("conv_enable", {15'h0, conv_en}, 16'h0000);
        conv(13'h0100);
        rreg(3'h5, 16'hc400);
        wreg(3'h1, 16'h0009);
        chk("conv_enable", {15'h0, conv_en}, 16'h0001);
        $display("test interrupt done");
        wreg(3'h1, 16'h00c0);
        rreg(3'h1, 16'h00c0);
        wreg(3'h2, 16'h0100);
        rreg(3'h2, 16'h0190);
        wreg(3'h4, 16'h0100);
        rreg(3'h4, 16'h0320);
        wreg(3'h1, 16'h07cf);
        rreg(3'h1, 16'h00c0);
        wreg(3'h1, 16'h0000);
        rreg(3'h1, 16'h00c0);
        $display("test locks done");
        u_tle_host_model.stall(1'b1);
        repeat (62) @(negedge lclk);
        chk("timeout", {15'h0, tmo}, 16'h0001);
        u_tle_host_model.stall(1'b0);
        repeat (20) @(negedge lclk);
        chk("timeout", {15'h0, tmo}, 16'h0000);
        $display("test timeout done");
        end_of_test();
    end
endmodule
